/* File: verilog/aifr_regs.sv */
// aifr_regs: identification and diagnostic holding-register bank of the actuator
`timescale 1ns/100ps
`default_nettype none

module aifr_regs
    import aifr_pkg::*;
#(
    parameter logic [15:0] APP_REV_MAJOR  = REV_RST,  // fixed at firmware build
    parameter logic [15:0] APP_REV_MINOR  = REV_RST,
    parameter logic [15:0] APP_REV_MOD    = REV_RST,
    parameter logic [15:0] APP_REV_BUILD  = REV_RST,
    parameter logic [15:0] BOOT_REV_MAJOR = REV_RST,  // fixed at boot code build
    parameter logic [15:0] BOOT_REV_MINOR = REV_RST,
    parameter logic [15:0] BOOT_REV_MOD   = REV_RST,
    parameter logic [15:0] BOOT_REV_BUILD = REV_RST
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // holding-register access, one word per cycle
    input  wire logic        mb_valid,
    input  wire logic        mb_first,
    input  wire logic        mb_last,
    input  wire logic        mb_write,
    input  wire logic [15:0] mb_addr,
    input  wire logic [15:0] mb_wdata,
    output logic             mb_ack,
    output logic             mb_exc,
    output logic      [15:0] mb_rdata,
    // fault events
    input  wire logic        ev_nvm_fault,
    input  wire logic        ev_stall,
    input  wire logic        contact_closed,
    input  wire logic        ev_fatal,
    input  wire logic        ev_ain_cal_bad,
    input  wire logic        ev_travel_cal_bad,
    input  wire logic        fault_clr,
    // actions
    output logic             restore_defaults,
    output logic             motion_stop,
    output logic             drive_safe,
    output logic             shutdown
);

    if (TS_W != 2 * WORD_W) begin : g_chk
        $error("aifr_regs: a timestamp must span exactly two words");
    end

    // map a register number onto a word index, IDX_NONE when unmapped
    function automatic logic [4:0] word_index(input logic [15:0] addr);
        logic [15:0] off;
        off = addr - ADDR_APP_MAJOR;
        if (addr >= ADDR_APP_MAJOR && addr <= ADDR_FAULT) begin
            word_index = off[4:0];
        end else begin
            word_index = IDX_NONE;
        end
    endfunction

    typedef struct packed {
        aifr_cmd_e   cmd;
        logic        ack;
        logic        exc;
        logic [15:0] rdata;
    } aifr_top_s;

    aifr_top_s s_r;
    aifr_top_s s_nxt;

    logic [4:0]      idx;                 // decoded index of the current word
    logic            first_eff;           // word opens a command
    logic            last_eff;            // word closes a command
    logic [15:0]     fault_word;          // from the fault block
    logic [TS_W-1:0] ts_live [NUM_TS];    // committed timestamps
    logic [TS_W-1:0] ts_snap [NUM_TS];    // timestamps frozen at command start
    logic [TS_W-1:0] ts_rd   [NUM_TS];    // what a read of this command sees

    assign idx = word_index(mb_addr);

    // a word arriving with no command open is treated as a fresh command,
    // so a master that never marks first still gets coherent pairs
    assign first_eff = mb_valid & (mb_first | (s_r.cmd == AIFR_CMD_IDLE));
    assign last_eff  = mb_valid & mb_last;

    // three timestamp pairs, high word at the lower register number
    for (genvar k = 0; k < NUM_TS; k++) begin : g_ts
        localparam logic [4:0] HI_IDX = IDX_TS_BASE + 5'(2 * k);
        localparam logic [4:0] LO_IDX = IDX_TS_BASE + 5'(2 * k + 1);
        logic wr_hi;
        logic wr_lo;
        // only whole commands move data into the live value
        assign wr_hi = mb_valid & mb_write & (idx == HI_IDX);
        assign wr_lo = mb_valid & mb_write & (idx == LO_IDX);
        aifr_ts_pair #(
            .HALF_W (WORD_W)
        ) u_ts (
            .sys_clk   (sys_clk),
            .rst_n     (rst_n),
            .cmd_first (first_eff),
            .cmd_last  (last_eff),
            .wr_hi     (wr_hi),
            .wr_lo     (wr_lo),
            .wdata     (mb_wdata),
            .live      (ts_live[k]),
            .snap      (ts_snap[k])
        );
        // the opening word reads live, which is what the snapshot captures
        assign ts_rd[k] = first_eff ? ts_live[k] : ts_snap[k];
    end

    // diagnostic fault word and its actions
    aifr_fault_flags u_flt (
        .sys_clk           (sys_clk),
        .rst_n             (rst_n),
        .ev_nvm_fault      (ev_nvm_fault),
        .ev_stall          (ev_stall),
        .contact_closed    (contact_closed),
        .ev_fatal          (ev_fatal),
        .ev_ain_cal_bad    (ev_ain_cal_bad),
        .ev_travel_cal_bad (ev_travel_cal_bad),
        .fault_clr         (fault_clr),
        .fault_word        (fault_word),
        .restore_defaults  (restore_defaults),
        .motion_stop       (motion_stop),
        .drive_safe        (drive_safe),
        .shutdown          (shutdown)
    );

    // access answer: every word is acknowledged one cycle after it is taken
    always_comb begin
        s_nxt       = s_r;
        s_nxt.ack   = mb_valid;
        s_nxt.exc   = 1'b0;
        s_nxt.rdata = 16'h0000;
        // command framing
        if (last_eff) begin
            s_nxt.cmd = AIFR_CMD_IDLE;
        end else if (mb_valid) begin
            s_nxt.cmd = AIFR_CMD_OPEN;
        end
        if (mb_valid) begin
            unique case (idx)
                5'h00: s_nxt.rdata = APP_REV_MAJOR;
                5'h01: s_nxt.rdata = APP_REV_MINOR;
                5'h02: s_nxt.rdata = APP_REV_MOD;
                5'h03: s_nxt.rdata = APP_REV_BUILD;
                5'h04: s_nxt.rdata = BOOT_REV_MAJOR;
                5'h05: s_nxt.rdata = BOOT_REV_MINOR;
                5'h06: s_nxt.rdata = BOOT_REV_MOD;
                5'h07: s_nxt.rdata = BOOT_REV_BUILD;
                5'h08: s_nxt.rdata = ts_rd[0][31:16];
                5'h09: s_nxt.rdata = ts_rd[0][15:0];
                5'h0a: s_nxt.rdata = ts_rd[1][31:16];
                5'h0b: s_nxt.rdata = ts_rd[1][15:0];
                5'h0c: s_nxt.rdata = ts_rd[2][31:16];
                5'h0d: s_nxt.rdata = ts_rd[2][15:0];
                IDX_FAULT: s_nxt.rdata = fault_word;
                default: s_nxt.exc = 1'b1;                      // unmapped number
            endcase
            // writes to read-only words are acknowledged and dropped
            if (mb_write) begin
                s_nxt.rdata = 16'h0000;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{cmd: AIFR_CMD_IDLE, ack: 1'b0, exc: 1'b0, rdata: 16'h0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mb_ack   = s_r.ack;
    assign mb_exc   = s_r.exc;
    assign mb_rdata = s_r.rdata;

    // checks

    property p_app_rev_read;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_valid && !mb_write && mb_addr == ADDR_APP_BUILD
            |=> mb_ack && !mb_exc && mb_rdata == APP_REV_BUILD;
    endproperty
    a_app_rev_read: assert property (p_app_rev_read)
        else $error("app build revision read wrong");

    property p_boot_rev_read;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_valid && !mb_write && mb_addr == ADDR_BOOT_MAJOR
            |=> mb_ack && mb_rdata == BOOT_REV_MAJOR;
    endproperty
    a_boot_rev_read: assert property (p_boot_rev_read)
        else $error("boot major revision read wrong");

    property p_board_commit;
        @(posedge sys_clk) disable iff (!rst_n)
        (mb_valid && mb_write && mb_addr == ADDR_BOARD_HI && !mb_last)
            ##1 (mb_valid && mb_write && mb_addr == ADDR_BOARD_LO && mb_last)
            |=> ts_live[0] == {$past(mb_wdata, 2), $past(mb_wdata)};
    endproperty
    a_board_commit: assert property (p_board_commit)
        else $error("board test date not committed as a pair");

    property p_motor_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_valid && mb_write && mb_addr == ADDR_MOTOR_HI && !mb_last
            |=> ts_live[1] == $past(ts_live[1]);
    endproperty
    a_motor_hold: assert property (p_motor_hold)
        else $error("motor test date changed before command end");

    property p_asm_read;
        @(posedge sys_clk) disable iff (!rst_n)
        first_eff && !mb_write && mb_addr == ADDR_ASM_LO
            |=> mb_rdata == $past(ts_live[2][15:0]);
    endproperty
    a_asm_read: assert property (p_asm_read)
        else $error("assembly date low word read wrong");

    property p_nvm;
        @(posedge sys_clk) disable iff (!rst_n)
        ev_nvm_fault && !fault_word[FLT_NVM_BIT]
            |=> restore_defaults && fault_word[FLT_NVM_BIT] ##1 !restore_defaults;
    endproperty
    a_nvm: assert property (p_nvm)
        else $error("memory fault did not restore once and flag");

    property p_stall;
        @(posedge sys_clk) disable iff (!rst_n)
        ev_stall |=> fault_word[FLT_STALL_BIT] && motion_stop;
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall did not stop motion");

    property p_override;
        @(posedge sys_clk) disable iff (!rst_n)
        contact_closed [*2] |-> fault_word[FLT_OVR_BIT] && drive_safe;
    endproperty
    a_override: assert property (p_override)
        else $error("closed contact did not drive safe position");

    property p_fatal;
        @(posedge sys_clk) disable iff (!rst_n)
        ev_fatal |=> shutdown && motion_stop && fault_word[FLT_FATAL_BIT];
    endproperty
    a_fatal: assert property (p_fatal)
        else $error("fatal error did not shut down");

    property p_aincal;
        @(posedge sys_clk) disable iff (!rst_n)
        ev_ain_cal_bad |=> fault_word[FLT_AINCAL_BIT];
    endproperty
    a_aincal: assert property (p_aincal)
        else $error("analog calibration flag not set");

    property p_travel;
        @(posedge sys_clk) disable iff (!rst_n)
        ev_travel_cal_bad ##1 !fault_clr |=> fault_word[FLT_TRAVEL_BIT];
    endproperty
    a_travel: assert property (p_travel)
        else $error("travel flag not set or not held");

    property p_ro_write;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_valid && mb_write && mb_addr == ADDR_FAULT && !ev_stall
            && !ev_nvm_fault && !ev_fatal && !ev_ain_cal_bad && !ev_travel_cal_bad
            && !fault_clr && $stable(contact_closed)
            |=> mb_ack && !mb_exc && $stable(fault_word);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to fault word had an effect");

    // a revision write is answered like a read of nothing, never as an exception
    property p_rev_write;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_valid && mb_write && mb_addr >= ADDR_APP_MAJOR && mb_addr <= ADDR_BOOT_BUILD
            |=> mb_ack && !mb_exc && mb_rdata == 16'h0000;
    endproperty
    a_rev_write: assert property (p_rev_write)
        else $error("write to revision word not dropped cleanly");

    // the fault word read returns the flags standing when the word was taken
    property p_fault_read;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_valid && !mb_write && mb_addr == ADDR_FAULT
            |=> mb_ack && !mb_exc && mb_rdata == $past(fault_word);
    endproperty
    a_fault_read: assert property (p_fault_read)
        else $error("fault word read wrong");

endmodule
`default_nettype wire

/* File: verilog/aifr_pkg.sv */
// aifr_pkg: register map, fault bit layout, reset values and types of the ident/fault bank
package aifr_pkg;

    // word sizes of the holding-register map
    localparam int WORD_W = 16;
    localparam int TS_W   = 32;
    localparam int NUM_TS = 3;

    // holding-register addresses (protocol register numbers)
    localparam logic [15:0] ADDR_APP_MAJOR  = 16'h9cbc;
    localparam logic [15:0] ADDR_APP_MINOR  = 16'h9cbd;
    localparam logic [15:0] ADDR_APP_MOD    = 16'h9cbe;
    localparam logic [15:0] ADDR_APP_BUILD  = 16'h9cbf;
    localparam logic [15:0] ADDR_BOOT_MAJOR = 16'h9cc0;
    localparam logic [15:0] ADDR_BOOT_MINOR = 16'h9cc1;
    localparam logic [15:0] ADDR_BOOT_MOD   = 16'h9cc2;
    localparam logic [15:0] ADDR_BOOT_BUILD = 16'h9cc3;
    localparam logic [15:0] ADDR_BOARD_HI   = 16'h9cc4;
    localparam logic [15:0] ADDR_BOARD_LO   = 16'h9cc5;
    localparam logic [15:0] ADDR_MOTOR_HI   = 16'h9cc6;
    localparam logic [15:0] ADDR_MOTOR_LO   = 16'h9cc7;
    localparam logic [15:0] ADDR_ASM_HI     = 16'h9cc8;
    localparam logic [15:0] ADDR_ASM_LO     = 16'h9cc9;
    localparam logic [15:0] ADDR_FAULT      = 16'h9cca;

    // internal word index produced by the address decoder
    localparam logic [4:0] IDX_TS_BASE = 5'h08;
    localparam logic [4:0] IDX_FAULT   = 5'h0e;
    localparam logic [4:0] IDX_NONE    = 5'h1f;

    // reset values
    localparam logic [15:0] REV_RST   = 16'h0000;
    localparam logic [31:0] TS_RST    = 32'h0000_0000;
    localparam logic [15:0] FAULT_RST = 16'h0000;

    // fault word bit positions
    localparam int FLT_NVM_BIT    = 15;
    localparam int FLT_STALL_BIT  = 14;
    localparam int FLT_OVR_BIT    = 13;
    localparam int FLT_FATAL_BIT  = 12;
    localparam int FLT_AINCAL_BIT = 11;
    localparam int FLT_TRAVEL_BIT = 10;

    // command tracking state
    typedef enum logic {
        AIFR_CMD_IDLE,
        AIFR_CMD_OPEN
    } aifr_cmd_e;

endpackage

/* File: verilog/aifr_ts_pair.sv */
// aifr_ts_pair: one 32-bit timestamp held over two words, with staging and read snapshot
`timescale 1ns/100ps
`default_nettype none
module aifr_ts_pair
    import aifr_pkg::*;
#(
    parameter int HALF_W = WORD_W    // width of one holding register
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // command framing
    input  wire logic                  cmd_first,   // first word of a command
    input  wire logic                  cmd_last,    // last word of a command
    // word writes
    input  wire logic                  wr_hi,
    input  wire logic                  wr_lo,
    input  wire logic [HALF_W-1:0]     wdata,
    // values
    output logic      [2*HALF_W-1:0]   live,        // committed value
    output logic      [2*HALF_W-1:0]   snap         // value frozen at command start
);

    if (HALF_W < 1 || HALF_W > WORD_W) begin : g_chk
        $error("aifr_ts_pair: HALF_W must be 1..16");
    end

    typedef struct packed {
        logic [2*HALF_W-1:0] live;
        logic [2*HALF_W-1:0] snap;
        logic [2*HALF_W-1:0] stg;   // words written so far in this command
        logic                hi_v;
        logic                lo_v;
    } aifr_ts_s;

    aifr_ts_s s_r;
    aifr_ts_s s_nxt;

    // staging: halves only reach the live value at the command's last word, so a
    // reader never sees one new half beside one old half of a pair written in one command
    always_comb begin
        s_nxt = s_r;
        if (cmd_first) begin
            s_nxt.snap = s_r.live;
            s_nxt.hi_v = 1'b0;
            s_nxt.lo_v = 1'b0;
        end
        if (wr_hi) begin
            s_nxt.stg[2*HALF_W-1:HALF_W] = wdata;
            s_nxt.hi_v                   = 1'b1;
        end
        if (wr_lo) begin
            s_nxt.stg[HALF_W-1:0] = wdata;
            s_nxt.lo_v            = 1'b1;
        end
        // commit; a lone half merges with the other, unchanged half
        if (cmd_last) begin
            if (s_nxt.hi_v) begin
                s_nxt.live[2*HALF_W-1:HALF_W] = s_nxt.stg[2*HALF_W-1:HALF_W];
            end
            if (s_nxt.lo_v) begin
                s_nxt.live[HALF_W-1:0] = s_nxt.stg[HALF_W-1:0];
            end
            s_nxt.hi_v = 1'b0;
            s_nxt.lo_v = 1'b0;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{live: TS_RST[2*HALF_W-1:0], snap: TS_RST[2*HALF_W-1:0],
                     stg: TS_RST[2*HALF_W-1:0], hi_v: 1'b0, lo_v: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign live = s_r.live;
    assign snap = s_r.snap;

endmodule
`default_nettype wire

/* File: verilog/aifr_fault_flags.sv */
// aifr_fault_flags: diagnostic fault word, upper bits, with the actions they trigger
`timescale 1ns/100ps
`default_nettype none
module aifr_fault_flags
    import aifr_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // fault events
    input  wire logic        ev_nvm_fault,
    input  wire logic        ev_stall,
    input  wire logic        contact_closed,
    input  wire logic        ev_fatal,
    input  wire logic        ev_ain_cal_bad,
    input  wire logic        ev_travel_cal_bad,
    input  wire logic        fault_clr,        // clears the sticky bits
    // status and actions
    output logic      [15:0] fault_word,
    output logic             restore_defaults, // one-cycle pulse
    output logic             motion_stop,
    output logic             drive_safe,
    output logic             shutdown
);

    typedef struct packed {
        logic [15:0] word;
        logic        restore;
    } aifr_flt_s;

    aifr_flt_s s_r;
    aifr_flt_s s_nxt;

    // sticky bits: clear first, then set, so an event in the clear cycle survives
    always_comb begin
        s_nxt = s_r;
        if (fault_clr) begin
            s_nxt.word = FAULT_RST;
        end
        // restore fires once per fresh memory fault
        s_nxt.restore = ev_nvm_fault & ~s_r.word[FLT_NVM_BIT];
        if (ev_nvm_fault) begin
            s_nxt.word[FLT_NVM_BIT] = 1'b1;
        end
        if (ev_stall) begin
            s_nxt.word[FLT_STALL_BIT] = 1'b1;
        end
        // override bit follows the contact level, it is not sticky
        s_nxt.word[FLT_OVR_BIT] = contact_closed;
        if (ev_fatal) begin
            s_nxt.word[FLT_FATAL_BIT] = 1'b1;
        end
        if (ev_ain_cal_bad) begin
            s_nxt.word[FLT_AINCAL_BIT] = 1'b1;
        end
        if (ev_travel_cal_bad) begin
            s_nxt.word[FLT_TRAVEL_BIT] = 1'b1;
        end
        // bits 9..0 are not kept here
        s_nxt.word[9:0] = FAULT_RST[9:0];
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{word: FAULT_RST, restore: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // motion_stop, drive_safe and shutdown held while their flag stands; a fatal error also stops motion
    assign fault_word       = s_r.word;
    assign restore_defaults = s_r.restore;
    assign motion_stop      = s_r.word[FLT_STALL_BIT] | s_r.word[FLT_FATAL_BIT];
    assign drive_safe       = s_r.word[FLT_OVR_BIT];
    assign shutdown         = s_r.word[FLT_FATAL_BIT];

endmodule
`default_nettype wire

/* File: verif/aifr_master.sv */
// aifr_master: modbus master model issuing word accesses to the register bank
`timescale 1ns/100ps
`default_nettype none
module aifr_master (
    // clock
    input  wire logic        sys_clk,
    // word request
    output logic             mb_valid,
    output logic             mb_first,
    output logic             mb_last,
    output logic             mb_write,
    output logic      [15:0] mb_addr,
    output logic      [15:0] mb_wdata,
    // answer
    input  wire logic        mb_ack,
    input  wire logic        mb_exc,
    input  wire logic [15:0] mb_rdata
);
    logic [16:0] rq[$];  // answers as {exc, data}, oldest first

    // idle bus at time zero
    initial begin
        mb_valid = 1'b0;
        mb_first = 1'b0;
        mb_last  = 1'b0;
        mb_write = 1'b0;
        mb_addr  = 16'h0000;
        mb_wdata = 16'h0000;
    end

    // answers stand one cycle, so log them mid-cycle
    always @(negedge sys_clk) begin
        if (mb_ack === 1'b1) begin
            rq.push_back({mb_exc, mb_rdata});
        end
    end

    // one word, changed at the falling edge only
    task automatic put(input logic f, l, w, input logic [15:0] a, dat);
        @(negedge sys_clk);
        mb_valid = 1'b1;
        mb_first = f;
        mb_last  = l;
        mb_write = w;
        mb_addr  = a;
        mb_wdata = dat;
    endtask

    // valid drops and address and data flip so a stale value never looks valid
    task automatic idle();
        @(negedge sys_clk);
        mb_valid = 1'b0;
        mb_addr  = ~mb_addr;
        mb_wdata = ~mb_wdata;
    endtask

    // both halves go in one command, keeping the 32-bit value coherent
    task automatic pair(input logic w, input logic [15:0] a, hi, lo);
        put(1'b1, 1'b0, w, a, hi);
        put(1'b0, 1'b1, w, a + 16'h0001, lo);
        idle();
    endtask
endmodule
`default_nettype wire

/* File: verif/aifr_regs_test.sv */
// aifr_regs_test: self-checking bench for the ident and fault register bank
`timescale 1ns/100ps
`default_nettype none
module aifr_regs_test;
    import aifr_pkg::*;
    logic        sys_clk = 1'b0;   // 10 MHz
    logic        rst_n   = 1'b0;
    logic        v, f, l, w, ack, exc;
    logic [15:0] a, d, rd;
    logic [5:0]  ev      = 6'h00;  // fault events, index i sets bit 10+i
    logic        clr     = 1'b0;
    logic        rs, ms, ds, sd;   // action outputs
    int          n_mismatch = 0;
    int          checked    = 0;
    int          cyc        = 0;
    // revision words given to the bank, app major first; all distinct from zero
    localparam logic [7:0][15:0] REV = {16'h0b04, 16'h0b03, 16'h0b02, 16'h0b01,
                                        16'h0a04, 16'h0a03, 16'h0a02, 16'h0a01};

    always #50 sys_clk = ~sys_clk;

    aifr_master aifr_master_i (.sys_clk(sys_clk), .mb_valid(v), .mb_first(f), .mb_last(l),
        .mb_write(w), .mb_addr(a), .mb_wdata(d), .mb_ack(ack), .mb_exc(exc), .mb_rdata(rd));

    aifr_regs #(.APP_REV_MAJOR(REV[0]), .APP_REV_MINOR(REV[1]), .APP_REV_MOD(REV[2]),
        .APP_REV_BUILD(REV[3]), .BOOT_REV_MAJOR(REV[4]), .BOOT_REV_MINOR(REV[5]),
        .BOOT_REV_MOD(REV[6]), .BOOT_REV_BUILD(REV[7])) aifr_regs_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .mb_valid(v), .mb_first(f), .mb_last(l),
        .mb_write(w), .mb_addr(a), .mb_wdata(d), .mb_ack(ack), .mb_exc(exc), .mb_rdata(rd),
        .ev_nvm_fault(ev[5]), .ev_stall(ev[4]), .contact_closed(ev[3]), .ev_fatal(ev[2]),
        .ev_ain_cal_bad(ev[1]), .ev_travel_cal_bad(ev[0]), .fault_clr(clr),
        .restore_defaults(rs), .motion_stop(ms), .drive_safe(ds), .shutdown(sd));

    task automatic mis(input string m);
        n_mismatch++;
        $display("mismatch t=%0t %s", $time, m);
    endtask

    // word answer compare, {exc, data}
    task automatic chkw(input logic [16:0] e, g);
        checked++;
        if (g !== e) mis($sformatf("word exp %h got %h", e, g));
    endtask

    // single flag compare
    task automatic chkb(input logic e, g, input string m);
        checked++;
        if (g !== e) mis(m);
    endtask

    // take the oldest logged answer; a missing one is a fault too
    task automatic expw(input logic [16:0] e);
        if (aifr_master_i.rq.size() == 0) mis("no answer");
        else chkw(e, aifr_master_i.rq.pop_front());
    endtask

    // single-word command, then wait until its answer is logged
    task automatic one(input logic wr, input logic [15:0] adr, dat);
        aifr_master_i.put(1'b1, 1'b1, wr, adr, dat);
        aifr_master_i.idle();
        @(posedge sys_clk);
    endtask

    // revision words read back fixed and ignore writes
    task automatic test_rev();
        for (int i = 0; i < 8; i++) begin
            one(1'b0, ADDR_APP_MAJOR + 16'(i), 16'h0000);
            expw({1'b0, REV[i]});
        end
        one(1'b1, ADDR_APP_MAJOR, 16'hffff);
        expw(17'h00000);
        one(1'b0, ADDR_APP_MAJOR, 16'h0000);
        expw({1'b0, REV[0]});
        one(1'b0, 16'h9ccb, 16'h0000);
        expw(17'h10000);  // unmapped word answers with the exception flag
        $display("test rev done");
    endtask

    // each timestamp starts at zero and stores a full 32-bit value
    task automatic test_ts();
        logic [15:0] b;
        for (int k = 0; k < 3; k++) begin
            b = ADDR_BOARD_HI + 16'(2 * k);
            aifr_master_i.pair(1'b0, b, 16'h0000, 16'h0000);
            @(posedge sys_clk);
            expw(17'h00000);
            expw(17'h00000);
            aifr_master_i.pair(1'b1, b, 16'h5a00 + 16'(k), 16'hc3a5);
            aifr_master_i.pair(1'b0, b, 16'h0000, 16'h0000);
            @(posedge sys_clk);
            expw(17'h00000);
            expw(17'h00000);
            expw({1'b0, 16'h5a00 + 16'(k)});
            expw(17'h0c3a5);
            // a lone low half merges with the kept high half; low read opens its command
            one(1'b1, b + 16'h0001, 16'h1234);
            expw(17'h00000);
            one(1'b0, b + 16'h0001, 16'h0000);
            expw(17'h01234);
            aifr_master_i.pair(1'b0, b, 16'h0000, 16'h0000);
            @(posedge sys_clk);
            expw({1'b0, 16'h5a00 + 16'(k)});
            expw(17'h01234);
        end
        $display("test ts done");
    endtask

    // every fault event sets its bit, and its action where it has one, one cycle later
    task automatic test_flt();
        for (int i = 0; i < 6; i++) begin
            @(negedge sys_clk);
            ev[i] = 1'b1;
            @(negedge sys_clk);
            chkb(i == 5, rs, "restore");
            chkb(i == 4 || i == 2, ms, "stop");
            chkb(i == 3, ds, "safe");
            chkb(i == 2, sd, "shutdown");
            if (i != 3) ev[i] = 1'b0;
            @(negedge sys_clk);
            chkb(1'b0, rs, "restore length");
            one(1'b1, ADDR_FAULT, 16'hffff);
            expw(17'h00000);
            one(1'b0, ADDR_FAULT, 16'h0000);
            expw({1'b0, 16'h0001 << (10 + i)});
            @(negedge sys_clk);
            ev[3] = 1'b0;
            clr   = 1'b1;
            @(negedge sys_clk);
            clr = 1'b0;
            one(1'b0, ADDR_FAULT, 16'h0000);
            expw(17'h00000);
        end
        $display("test flt done");
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("counts checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // the whole run needs about 150 cycles; a hang is cut off
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        test_rev();
        test_ts();
        test_flt();
        end_sim();
    end
endmodule
`default_nettype wire
